// ==== inc/iep_pkg.sv ====
// constants, offsets and types of the interrupt enable and priority block
package iep_pkg;
  localparam int NSRC = 16;
  localparam int LVLW = 2;
  typedef logic [LVLW-1:0] iep_level_t;
  typedef logic [3:0] iep_src_t;
  typedef logic [NSRC-1:0] iep_vec_t;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_EXT_EN = 8'hE8;
  localparam logic [7:0] IDX_EXT_PH = 8'hF7;
  localparam logic [7:0] IDX_EXT_PL = 8'hFF;
  localparam logic [7:0] IDX_BAS_EN = 8'hA8;
  localparam logic [7:0] IDX_BAS_PH = 8'hB7;
  localparam logic [7:0] IDX_BAS_PL = 8'hB8;
  localparam logic [7:0] IDX_STAT = 8'hC0;
  localparam logic [7:0] IDX_MASK = 8'hC1;
  localparam logic [7:0] IDX_PEND_LO = 8'hC2;
  localparam logic [7:0] IDX_PEND_HI = 8'hC3;
  localparam logic [7:0] IDX_SERVICE = 8'hC4;
  // reset values
  localparam logic [7:0] RST_EXT_EN = 8'h00;
  localparam logic [7:0] RST_EXT_PH = 8'h00;
  localparam logic [7:0] RST_EXT_PL = 8'h00;
  localparam logic [7:0] RST_BAS_EN = 8'h00;
  localparam logic [7:0] RST_BAS_PH = 8'h00;
  localparam logic [7:0] RST_BAS_PL = 8'h00;
  localparam logic [7:0] RST_EV = 8'h00;
  localparam logic [3:0] RST_SERVICE = 4'h0;
  // writable bits
  localparam logic [7:0] EXT_EN_WMASK = 8'hF7;
  localparam logic [7:0] EXT_PRIO_WMASK = 8'hF3;
  localparam logic [7:0] BAS_WMASK = 8'h7F;
  localparam logic [7:0] BAS_EN_WMASK = 8'hFF;
  localparam logic [7:0] EV_WMASK = 8'h07;
  // field positions
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_TMR0 = 1;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_TMR1 = 3;
  localparam int BIT_UART = 4;
  localparam int EV_DISPATCH = 0;
  localparam int EV_NEST = 1;
  localparam int EV_RETURN = 2;
  localparam int SYNC_STAGES = 2;
endpackage

// ==== inc/iep_arb_if.sv ====
// request vector and winner between the register block and the arbiter
`timescale 1ns/1ps
`default_nettype none
interface iep_arb_if;
  import iep_pkg::*;
  iep_vec_t req;
  iep_vec_t prio_h;
  iep_vec_t prio_l;
  logic win_valid;
  iep_src_t win_idx;
  iep_level_t win_lvl;
  modport ctl (output req, output prio_h, output prio_l,
    input win_valid, input win_idx, input win_lvl);
  modport arb (input req, input prio_h, input prio_l,
    output win_valid, output win_idx, output win_lvl);
endinterface
`default_nettype wire

// ==== core/iep_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module iep_sync #(
  parameter int W = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // idle pins are high, so the chain resets high
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          meta_reg[g] <= 1'b1;
          q_reg[g] <= 1'b1;
        end else begin
          meta_reg[g] <= d_in[g];
          q_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate
  assign q_out = q_reg;
endmodule // iep_sync
`default_nettype wire

// ==== core/iep_arbiter.sv ====
// picks the highest level pending request, lowest index on a tie
`timescale 1ns/1ps
`default_nettype none
module iep_arbiter (
  iep_arb_if.arb bus
);
  import iep_pkg::*;
  always_comb begin
    bus.win_valid = 1'b0;
    bus.win_idx = '0;
    bus.win_lvl = '0;
    // walk downward so a lower index overrides on equal level [R15]
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (bus.req[i] && (!bus.win_valid || {bus.prio_h[i], bus.prio_l[i]} >= bus.win_lvl)) begin
        bus.win_valid = 1'b1;
        bus.win_idx = iep_src_t'(i);
        bus.win_lvl = {bus.prio_h[i], bus.prio_l[i]}; // [R14]
      end
    end
  end
endmodule // iep_arbiter
`default_nettype wire

// ==== core/iep_ctrl.sv ====
// interrupt enable and priority block with its wishbone register file
// Operation
// R1: uart enable bit 4 gates tx/rx done
// R2: timer1 enable bit 3 gates overflow
// R3: ext1 enable bit 2 gates low pin
// R4: timer0 enable bit 1 gates overflow
// R5: ext0 enable bit 0 gates low pin
// R6: extended enable bit 7 gates timer2
// R7: extended enable bit 6 gates spi
// R8: extended enable bit 5 gates brake
// R9: watchdog, capture, keypad, i2c enables; bit 3 unused
// R10: extended low priority bits raise level
// R11: extended high priority bits give top level
// R12: basic high priority bits give top level
// R13: extended low priority resets to zero
// R14: four levels, preempt only when strictly higher
// R15: flag, enable and global enable; fixed tie order
`timescale 1ns/1ps
`default_nettype none
module iep_ctrl (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [9:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic UART_TX_DONE_IN,
  input wire logic UART_RX_DONE_IN,
  input wire logic TIMER0_OVF_IN,
  input wire logic TIMER1_OVF_IN,
  input wire logic TIMER2_IN,
  input wire logic BROWNOUT_IN,
  input wire logic CONVERTER_IN,
  input wire logic SPI_IN,
  input wire logic BRAKE_IN,
  input wire logic WATCHDOG_IN,
  input wire logic CAPTURE_IN,
  input wire logic KEYPAD_IN,
  input wire logic I2C_IN,
  input wire logic EXT_PIN_ZERO_N_IN,
  input wire logic EXT_PIN_ONE_N_IN,
  input wire logic IRQ_ACK_IN,
  input wire logic IRQ_RETI_IN,
  output logic IRQ_REQ_OUT,
  output iep_pkg::iep_src_t IRQ_SRC_OUT,
  output iep_pkg::iep_level_t IRQ_LEVEL_OUT,
  output logic INT_OUT
);
  import iep_pkg::*;

  iep_arb_if arb_bus ();
  logic [1:0] pin_sync;
  logic [7:0] ext_en_reg, ext_en_next;
  logic [7:0] ext_ph_reg, ext_ph_next;
  logic [7:0] ext_pl_reg, ext_pl_next;
  logic [7:0] bas_en_reg, bas_en_next;
  logic [7:0] bas_ph_reg, bas_ph_next;
  logic [7:0] bas_pl_reg, bas_pl_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] mask_reg, mask_next;
  logic [3:0] service_reg, service_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic req_reg, req_next;
  iep_src_t src_reg, src_next;
  iep_level_t lvl_reg, lvl_next;
  iep_vec_t flag;
  logic glob;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] ev;
  logic run_valid;
  iep_level_t run_lvl;

  iep_sync #(.W(2)) u_sync (
    .clk_in(CLK_SYS_IN),
    .rst_in(RST_IN),
    .d_in({EXT_PIN_ONE_N_IN, EXT_PIN_ZERO_N_IN}),
    .q_out(pin_sync)
  );

  iep_arbiter u_arb (
    .bus(arb_bus.arb)
  );

  // source flags, index order is the tie order
  always_comb begin
    flag = '0;
    flag[BIT_EXT0] = !pin_sync[0]; // [R5]
    flag[BIT_TMR0] = TIMER0_OVF_IN; // [R4]
    flag[BIT_EXT1] = !pin_sync[1]; // [R3]
    flag[BIT_TMR1] = TIMER1_OVF_IN; // [R2]
    flag[BIT_UART] = UART_TX_DONE_IN | UART_RX_DONE_IN; // [R1]
    flag[5] = BROWNOUT_IN;
    flag[6] = CONVERTER_IN;
    flag[8] = I2C_IN;
    flag[9] = KEYPAD_IN;
    flag[10] = CAPTURE_IN;
    flag[12] = WATCHDOG_IN;
    flag[13] = BRAKE_IN; // [R8]
    flag[14] = SPI_IN; // [R7]
    flag[15] = TIMER2_IN; // [R6]
  end

  assign glob = bas_en_reg[BIT_GLOBAL];
  // unused slots carry zero enables so they never request
  assign arb_bus.req = flag & {ext_en_reg & EXT_EN_WMASK, 1'b0, bas_en_reg[6:0]}
    & {NSRC{glob}}; // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8] [R9] [R15]
  assign arb_bus.prio_h = {ext_ph_reg, 1'b0, bas_ph_reg[6:0]}; // [R11] [R12]
  assign arb_bus.prio_l = {ext_pl_reg, 1'b0, bas_pl_reg[6:0]}; // [R10]

  // level of the handler now running: highest in-service bit
  always_comb begin
    run_valid = |service_reg;
    run_lvl = '0;
    for (int l = 0; l < 4; l++) begin
      if (service_reg[l]) begin
        run_lvl = iep_level_t'(l);
      end
    end
  end

  // request to the core; held off one cycle after an ack so that the
  // new in-service level is seen before the next compare
  always_comb begin
    req_next = arb_bus.win_valid && !IRQ_ACK_IN
      && (!run_valid || arb_bus.win_lvl > run_lvl); // [R14]
    src_next = arb_bus.win_idx;
    lvl_next = arb_bus.win_lvl;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      req_reg <= 1'b0;
      src_reg <= '0;
      lvl_reg <= '0;
    end else begin
      req_reg <= req_next;
      src_reg <= src_next;
      lvl_reg <= lvl_next;
    end
  end

  // in-service levels and events
  always_comb begin
    service_next = service_reg;
    ev = '0;
    if (IRQ_RETI_IN && run_valid) begin
      service_next[run_lvl] = 1'b0;
      ev[EV_RETURN] = 1'b1;
    end
    if (IRQ_ACK_IN && req_reg) begin
      service_next[lvl_reg] = 1'b1; // [R14]
      ev[EV_DISPATCH] = 1'b1;
      ev[EV_NEST] = run_valid;
    end
  end

  // wishbone decode
  assign wr = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !ack_reg && WB_SEL_IN[0];
  assign idx = WB_ADR_IN[9:2];
  assign wbyte = WB_DAT_IN[7:0];

  always_comb begin
    ext_en_next = ext_en_reg;
    ext_ph_next = ext_ph_reg;
    ext_pl_next = ext_pl_reg;
    bas_en_next = bas_en_reg;
    bas_ph_next = bas_ph_reg;
    bas_pl_next = bas_pl_reg;
    mask_next = mask_reg;
    // write-one-to-clear; a new event in the same cycle wins
    stat_next = stat_reg | ev;
    if (wr) begin
      if (idx == IDX_EXT_EN) begin
        ext_en_next = wbyte & EXT_EN_WMASK; // [R9]
      end else if (idx == IDX_EXT_PH) begin
        ext_ph_next = wbyte & EXT_PRIO_WMASK; // [R11]
      end else if (idx == IDX_EXT_PL) begin
        ext_pl_next = wbyte & EXT_PRIO_WMASK; // [R10]
      end else if (idx == IDX_BAS_EN) begin
        bas_en_next = wbyte & BAS_EN_WMASK;
      end else if (idx == IDX_BAS_PH) begin
        bas_ph_next = wbyte & BAS_WMASK; // [R12]
      end else if (idx == IDX_BAS_PL) begin
        bas_pl_next = wbyte & BAS_WMASK;
      end else if (idx == IDX_STAT) begin
        stat_next = (stat_reg & ~(wbyte & EV_WMASK)) | ev;
      end else if (idx == IDX_MASK) begin
        mask_next = wbyte & EV_WMASK;
      end
    end
  end

  always_comb begin
    ack_next = WB_CYC_IN && WB_STB_IN && !ack_reg;
    rdat_next = '0;
    if (idx == IDX_EXT_EN) begin
      rdat_next[7:0] = ext_en_reg;
    end else if (idx == IDX_EXT_PH) begin
      rdat_next[7:0] = ext_ph_reg;
    end else if (idx == IDX_EXT_PL) begin
      rdat_next[7:0] = ext_pl_reg;
    end else if (idx == IDX_BAS_EN) begin
      rdat_next[7:0] = bas_en_reg;
    end else if (idx == IDX_BAS_PH) begin
      rdat_next[7:0] = bas_ph_reg;
    end else if (idx == IDX_BAS_PL) begin
      rdat_next[7:0] = bas_pl_reg;
    end else if (idx == IDX_STAT) begin
      rdat_next[7:0] = stat_reg;
    end else if (idx == IDX_MASK) begin
      rdat_next[7:0] = mask_reg;
    end else if (idx == IDX_PEND_LO) begin
      rdat_next[7:0] = flag[7:0];
    end else if (idx == IDX_PEND_HI) begin
      rdat_next[7:0] = flag[15:8];
    end else if (idx == IDX_SERVICE) begin
      rdat_next[3:0] = service_reg;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      ext_en_reg <= RST_EXT_EN;
      ext_ph_reg <= RST_EXT_PH;
      ext_pl_reg <= RST_EXT_PL; // [R13]
      bas_en_reg <= RST_BAS_EN;
      bas_ph_reg <= RST_BAS_PH;
      bas_pl_reg <= RST_BAS_PL;
      stat_reg <= RST_EV;
      mask_reg <= RST_EV;
      service_reg <= RST_SERVICE;
      ack_reg <= 1'b0;
      rdat_reg <= '0;
    end else begin
      ext_en_reg <= ext_en_next;
      ext_ph_reg <= ext_ph_next;
      ext_pl_reg <= ext_pl_next;
      bas_en_reg <= bas_en_next;
      bas_ph_reg <= bas_ph_next;
      bas_pl_reg <= bas_pl_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      service_reg <= service_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign WB_ACK_OUT = ack_reg;
  assign WB_DAT_OUT = rdat_reg;
  assign IRQ_REQ_OUT = req_reg;
  assign IRQ_SRC_OUT = src_reg;
  assign IRQ_LEVEL_OUT = lvl_reg;
  assign INT_OUT = |(stat_reg & mask_reg);

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (RST_IN);

  property p_uart_gate;
    !bas_en_reg[BIT_UART] |-> !arb_bus.req[BIT_UART];
  endproperty
  a_uart_gate: assert property (p_uart_gate) else $error("uart request while disabled"); // [R1]

  property p_tmr1_gate;
    (TIMER1_OVF_IN && bas_en_reg[BIT_TMR1] && glob) |-> arb_bus.req[BIT_TMR1];
  endproperty
  a_tmr1_gate: assert property (p_tmr1_gate) else $error("timer1 request lost"); // [R2]

  property p_ext1_pin;
    (!EXT_PIN_ONE_N_IN && bas_en_reg[BIT_EXT1] && glob)[*3] |-> arb_bus.req[BIT_EXT1];
  endproperty
  a_ext1_pin: assert property (p_ext1_pin) else $error("ext1 low pin not requesting"); // [R3]

  property p_tmr0_gate;
    arb_bus.req[BIT_TMR0] |-> bas_en_reg[BIT_TMR0] && TIMER0_OVF_IN;
  endproperty
  a_tmr0_gate: assert property (p_tmr0_gate) else $error("timer0 request without cause"); // [R4]

  property p_ext0_idle;
    (EXT_PIN_ZERO_N_IN)[*3] |-> !arb_bus.req[BIT_EXT0];
  endproperty
  a_ext0_idle: assert property (p_ext0_idle) else $error("ext0 requests with pin high"); // [R5]

  property p_tmr2_gate;
    !ext_en_reg[7] |-> !arb_bus.req[15];
  endproperty
  a_tmr2_gate: assert property (p_tmr2_gate) else $error("timer2 request while disabled"); // [R6]

  property p_spi_gate;
    (SPI_IN && ext_en_reg[6] && glob) |-> arb_bus.req[14];
  endproperty
  a_spi_gate: assert property (p_spi_gate) else $error("spi request lost"); // [R7]

  property p_brake_gate;
    !ext_en_reg[5] |-> !arb_bus.req[13];
  endproperty
  a_brake_gate: assert property (p_brake_gate) else $error("brake request while disabled"); // [R8]

  property p_unused_bit;
    (wr && idx == IDX_EXT_EN) |=> !ext_en_reg[3] && ext_en_reg[2] == $past(wbyte[2]);
  endproperty
  a_unused_bit: assert property (p_unused_bit) else $error("extended enable write wrong"); // [R9]

  property p_reserved;
    ext_pl_reg[3:2] == 2'b00 && ext_ph_reg[3:2] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved priority bits set"); // [R10]

  property p_win_level;
    arb_bus.win_valid |-> arb_bus.win_lvl ==
      {arb_bus.prio_h[arb_bus.win_idx], arb_bus.prio_l[arb_bus.win_idx]};
  endproperty
  a_win_level: assert property (p_win_level) else $error("winner level mismatch"); // [R11]

  property p_ext_high;
    (arb_bus.req[15] && ext_ph_reg[7]) |-> arb_bus.win_lvl[1];
  endproperty
  a_ext_high: assert property (p_ext_high) else $error("timer2 high priority lost"); // [R11]

  property p_bas_high;
    (arb_bus.req[BIT_UART] && bas_ph_reg[BIT_UART]) |-> arb_bus.win_lvl[1];
  endproperty
  a_bas_high: assert property (p_bas_high) else $error("high priority not applied"); // [R12]

  property p_reset_low;
    $past(RST_IN) |-> ext_pl_reg == RST_EXT_PL;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("low priority not cleared"); // [R13]

  property p_preempt;
    IRQ_REQ_OUT |-> (!run_valid || IRQ_LEVEL_OUT > run_lvl);
  endproperty
  a_preempt: assert property (p_preempt) else $error("request not above running level"); // [R14]

  property p_global;
    !glob ##1 !glob |-> !IRQ_REQ_OUT;
  endproperty
  a_global: assert property (p_global) else $error("request with global enable off"); // [R15]

  property p_wb_ack;
    (WB_CYC_IN && WB_STB_IN && !ack_reg) |=> WB_ACK_OUT ##1 !WB_ACK_OUT;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");

  c_nest: cover property (IRQ_ACK_IN && req_reg && run_valid);
  c_reti: cover property (IRQ_RETI_IN && run_valid ##1 IRQ_REQ_OUT);
  c_clear: cover property (wr && idx == IDX_STAT && |ev);
endmodule // iep_ctrl
`default_nettype wire

// ==== bench/iep_core_model.sv ====
// behavioural core sequencer that accepts requests and returns from handlers
`timescale 1ns/1ps
`default_nettype none
module iep_core_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic auto_in,
  input wire logic reti_go_in,
  output logic ack_out,
  output logic reti_out
);
  // acks only while a request shows, one pulse; a slow core just keeps auto_in low
  always_ff @(posedge clk_in) begin
    ack_out <= !rst_in && auto_in && req_in && !ack_out;
    reti_out <= !rst_in && reti_go_in && !reti_out;
  end
endmodule // iep_core_model
`default_nettype wire

// ==== bench/iep_ctrl_tb_top.sv ====
// self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
module iep_ctrl_tb_top;
  import iep_pkg::*;
  localparam logic [7:0] IDXS [6] = '{IDX_BAS_EN, IDX_BAS_PH, IDX_BAS_PL,
    IDX_EXT_EN, IDX_EXT_PH, IDX_EXT_PL};
  localparam logic [7:0] WM [6] = '{BAS_EN_WMASK, BAS_WMASK, BAS_WMASK,
    EXT_EN_WMASK, EXT_PRIO_WMASK, EXT_PRIO_WMASK};
  logic clk, rst, cyc, stb, we, auto_ack, reti_go, ack_c, reti_c, ack, req, int_o;
  logic [9:0] adr;
  logic [31:0] wdat, rdat, q, seed, r1, r2;
  logic [15:0] flg;
  logic [7:0] m [6];
  iep_src_t src;
  iep_level_t lvl;
  int err_count, compares, cyc_cnt;

  iep_ctrl i_dut (
    .CLK_SYS_IN(clk), .RST_IN(rst),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(4'hF), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .UART_TX_DONE_IN(flg[4]), .UART_RX_DONE_IN(flg[7]),
    .TIMER0_OVF_IN(flg[1]), .TIMER1_OVF_IN(flg[3]), .TIMER2_IN(flg[15]),
    .BROWNOUT_IN(flg[5]), .CONVERTER_IN(flg[6]), .SPI_IN(flg[14]),
    .BRAKE_IN(flg[13]), .WATCHDOG_IN(flg[12]), .CAPTURE_IN(flg[10]),
    .KEYPAD_IN(flg[9]), .I2C_IN(flg[8]),
    .EXT_PIN_ZERO_N_IN(~flg[0]), .EXT_PIN_ONE_N_IN(~flg[2]),
    .IRQ_ACK_IN(ack_c), .IRQ_RETI_IN(reti_c),
    .IRQ_REQ_OUT(req), .IRQ_SRC_OUT(src), .IRQ_LEVEL_OUT(lvl), .INT_OUT(int_o)
  );

  iep_core_model i_core (
    .clk_in(clk), .rst_in(rst), .req_in(req), .auto_in(auto_ack),
    .reti_go_in(reti_go), .ack_out(ack_c), .reti_out(reti_c)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // a hang ends in the same report as a normal run
  always @(posedge clk) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 30000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // one classic cycle; waits for ack, no assumed latency
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // v holds {ext low, ext high, ext en, basic low, basic high, basic en}
  task automatic cfg(input logic [47:0] v);
    for (int k = 0; k < 6; k++) begin
      m[k] = v[8*k+:8] & WM[k];
      wb(1'b1, IDXS[k], v[8*k+:8]);
    end
  endtask

  task automatic expect_irq();
    logic [15:0] f, en, ph, pl;
    logic found;
    logic [3:0] bi;
    logic [1:0] bl;
    f = flg;
    f[4] = flg[4] | flg[7];
    f[7] = 1'b0;
    f[11] = 1'b0;
    en = {m[3], 1'b0, m[0][6:0]};
    ph = {m[4], 1'b0, m[1][6:0]};
    pl = {m[5], 1'b0, m[2][6:0]};
    found = 1'b0;
    bi = 4'h0;
    bl = 2'h0;
    for (int i = 0; i < 16; i++) begin
      if (f[i] && en[i] && m[0][7] && (!found || {ph[i], pl[i]} > bl)) begin
        found = 1'b1;
        bi = i[3:0];
        bl = {ph[i], pl[i]};
      end
    end
    chk({31'h0, req}, {31'h0, found});
    if (found) begin
      chk({28'h0, src}, {28'h0, bi});
      chk({30'h0, lvl}, {30'h0, bl});
    end
    // raw flags ignore enables; pins read active high once synchronised
    wb(1'b0, IDX_PEND_LO, 8'h00);
    chk(q, {24'h0, f[7:0]});
    wb(1'b0, IDX_PEND_HI, 8'h00);
    chk(q, {24'h0, f[15:8]});
  endtask

  task automatic reti_once();
    reti_go <= 1'b1;
    @(posedge clk);
    reti_go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    {cyc, stb, we, auto_ack, reti_go} = '0;
    adr = '0;
    wdat = '0;
    flg = '0;
    err_count = 0;
    compares = 0;
    cyc_cnt = 0;
    seed = 32'h45;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values, then writable bits only
    for (int k = 0; k < 6; k++) begin
      wb(1'b0, IDXS[k], 8'h00);
      chk(q, 32'h0);
    end
    cfg(48'hFFFF_FFFF_FFFF);
    for (int k = 0; k < 6; k++) begin
      wb(1'b0, IDXS[k], 8'h00);
      chk(q, {24'h0, WM[k]});
    end
    wb(1'b1, 8'h10, 8'hFF);
    wb(1'b0, 8'h10, 8'h00);
    chk(q, 32'h0);
    // each source alone, enabled and then blocked by its own bit
    for (int i = 0; i < 16; i++) begin
      r1 = 32'h1 << i;
      flg <= r1[15:0];
      cfg({24'h0, 8'hFF, 16'h0, 8'hFF});
      repeat (5) @(posedge clk);
      expect_irq();
      // receive-done sits on index 7, so its blocking bit is the uart enable
      cfg({16'h0, ~r1[15:8], 16'h0, 1'b1, ~r1[6:0] & ~{2'b00, r1[7], 4'h0}});
      repeat (5) @(posedge clk);
      expect_irq();
    end
    // random enables, levels and flags against the model
    for (int n = 0; n < 40; n++) begin
      r1 = xs();
      r2 = xs();
      cfg({r2[15:0], r1});
      r2 = xs();
      flg <= r2[15:0] & r2[31:16];
      repeat (5) @(posedge clk);
      expect_irq();
    end
    // nesting: level 0 handler, same level refused, level 2 preempts
    flg <= 16'h0;
    cfg({24'h0, 8'h00, 8'h00, 8'h82});
    wb(1'b1, IDX_STAT, 8'h07);
    wb(1'b1, IDX_MASK, 8'h07);
    flg <= 16'h0002;
    auto_ack <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, req}, 32'h0);
    wb(1'b0, IDX_SERVICE, 8'h00);
    chk(q, 32'h1);
    wb(1'b0, IDX_STAT, 8'h00);
    chk(q, 32'h1);
    chk({31'h0, int_o}, 32'h1);
    cfg({24'h0, 8'h00, 8'h08, 8'h8A});
    flg <= 16'h000A;
    repeat (6) @(posedge clk);
    wb(1'b0, IDX_SERVICE, 8'h00);
    chk(q, 32'h5);
    wb(1'b0, IDX_STAT, 8'h00);
    chk(q, 32'h3);
    auto_ack <= 1'b0;
    flg <= 16'h0;
    reti_once();
    wb(1'b0, IDX_SERVICE, 8'h00);
    chk(q, 32'h1);
    reti_once();
    wb(1'b0, IDX_SERVICE, 8'h00);
    chk(q, 32'h0);
    // write one to clear, then masking of the level output
    wb(1'b1, IDX_STAT, 8'h01);
    wb(1'b0, IDX_STAT, 8'h00);
    chk(q, 32'h6);
    wb(1'b1, IDX_MASK, 8'h00);
    @(posedge clk);
    chk({31'h0, int_o}, 32'h0);
    wb(1'b1, IDX_MASK, 8'h04);
    @(posedge clk);
    chk({31'h0, int_o}, 32'h1);
    final_report();
  end
endmodule // iep_ctrl_tb_top
`default_nettype wire
